/* dv/pio_group_bench.sv */
// Self-checking bench of the port group against a register model.
// Assumes the pin model and a single AXI4-Lite master.
`timescale 1ns/1ps
module pio_group_bench
   import pio_pkg::*;
   ;
   logic clk_sys, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, rd, w;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [PIO_NPORT-1:0][PIO_W-1:0] pin_in, alt_data, alt_in, ext;
   pio_pad_t [PIO_NPORT-1:0] pad;
   logic [2*PIO_NPORT-1:0] thr_sel;
   pio_ebus_t ebus;
   logic [7:0] segment_address_bits;
   logic [PIO_W-1:0] ebus_rdata, lat[PIO_NPORT], dir[PIO_NPORT];
   int num_errors, samples_checked;
   pio_group u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .pin_in(pin_in), .pad(pad), .thr_sel(thr_sel), .alt_data(alt_data), .alt_in(alt_in), .ebus(ebus),
      .segment_address_bits(segment_address_bits), .ebus_rdata(ebus_rdata));
   pio_pins u_pins (.pad(pad), .ext(ext), .pin_in(pin_in));
   initial begin
      clk_sys = 0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Source value of a read-modify-write, also what a data read returns.
   function automatic logic [31:0] src(int s);
      return {16'h0, ((dir[s] & lat[s]) | (~dir[s] & ext[s])) & PIO_IMPL[s]};
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("FAIL %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   // Each channel is held until its own ready, and bready until bvalid.
   task bus_wr(input logic [11:0] a, input logic [31:0] d);
      logic aw_done, w_done;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      {aw_done, w_done} = 2'h0;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end while (!(aw_done && w_done));
      do @(posedge clk_sys); while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task bus_rd(input logic [11:0] a);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do @(posedge clk_sys); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clk_sys); while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task complete_run();
      if (num_errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // The run needs a few hundred cycles; this bound cuts a hang.
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      complete_run();
   end
   initial begin
      {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {alt_data, ext, ebus, segment_address_bits} = '1;
      seed = 32'h694D;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1;
      bus_rd(12'h050);
      chk(rd, 32'h0);
      w = rnd();
      bus_wr(12'h180, w);
      bus_wr(12'h184, w >> 14);
      chk(thr_sel, 22'(w) & PIO_THR_MASK);
      for (int s = 4; s < 9; s++) begin
         w = rnd();
         ext[s] <= w[15:0];
         w = rnd();
         bus_wr(12'(4*s), w);
         lat[s] = w[15:0];
         w = rnd();
         bus_wr(12'(64+4*s), w);
         dir[s] = w[15:0] & PIO_IMPL[s] & {16{PIO_OUTCAP[s]}};
         bus_rd(12'(4*s));
         chk(rd, src(s));
         chk(pad[s].oe, dir[s]);
         chk(pad[s].out & dir[s], lat[s] & dir[s]);
         for (int k = 0; k < 2; k++) begin
            w = rnd();
            bus_wr(12'(256+64*k+4*s), w);
            lat[s] = 16'(k ? src(s) & ~w : src(s) | w);
            bus_rd(12'(4*s));
            chk(rd, src(s));
         end
         if (PIO_ODCAP[s]) begin
            bus_wr(12'(128+4*s), 32'hFFFF);
            chk(pad[s].oe, dir[s] & ~lat[s]);
            chk(pad[s].out & pad[s].oe, 16'h0);
            bus_wr(12'(128+4*s), 32'h0);
         end
         w = rnd();
         alt_data[s] <= w[15:0];
         bus_wr(12'(192+4*s), 32'hFFFF);
         repeat (3) @(posedge clk_sys);
         chk(pad[s].oe, dir[s]);
         chk(pad[s].out & dir[s], lat[s] & w[15:0] & dir[s]);
         chk(alt_in[s] & dir[s], lat[s] & dir[s]);
      end
      bus_rd(12'h1C0);
      chk(rd, 32'h0);
      chk(32'(rs), 32'(PIO_RESP_SLVERR));
      alt_data <= '1;
      bus_wr(12'h000, 32'hFF);
      bus_wr(12'h004, 32'hFF);
      bus_wr(12'h018, 32'hFF);
      w = rnd();
      ebus <= {1'b1, w[15:0]};
      segment_address_bits <= w[23:16];
      bus_wr(12'h188, 32'h3);
      repeat (3) @(posedge clk_sys);
      chk({pad[1].out[7:0], pad[0].out[7:0], pad[0].oe}, {w[15:0], 16'hFF});
      chk({pad[6].out[7:0], pad[6].oe}, {w[23:16], 16'hFF});
      // The data phase releases port 0 to the outside drive and returns its level to the bus controller.
      w = rnd();
      ebus.drive <= 1'b0;
      {ext[1][7:0], ext[0][7:0]} <= w[15:0];
      repeat (5) @(posedge clk_sys);
      chk(ebus_rdata, w[15:0]);
      chk(pad[0].oe, 16'h0);
      complete_run();
   end
endmodule // pio_group_bench

/* dv/pio_pins.sv */
// Board pins seen by the port group.
// Assumes pads from the group and an outside drive from the bench.
`timescale 1ns/1ps
module pio_pins
   import pio_pkg::*;
(
   // Pads and outside drive
   input pio_pad_t [PIO_NPORT-1:0] pad,
   input wire logic [PIO_NPORT-1:0][PIO_W-1:0] ext,
   // Levels at the pins
   output logic [PIO_NPORT-1:0][PIO_W-1:0] pin_in
);
   // outside drive yields
   // A driven pin shows its pad, and a released pin the outside level.
   always_comb begin
      for (int s = 0; s < PIO_NPORT; s++) begin
         pin_in[s] = (pad[s].oe & pad[s].out) | (~pad[s].oe & ext[s]);
      end
   end
endmodule // pio_pins

/* rtl/pio_group.sv */
// Parallel I/O port group: AXI4-Lite register file and eleven port slots.
// Assumes clk_sys at 40 MHz, a single bus master and pad cells outside.
//
// Function
// - Provide split ports 0/1, 16-line port 2, 15-line port 3, 8-line ports.
// - Port 5 has sixteen input-only lines with no driver.
// - Ports 2,3,4,6,7,8 select push-pull or open drain per pin.
// - Every pin is sampled into its input latch each state time.
// - Input pin: write updates latch only; read returns sampled pin.
// - Input pin: read-modify-write sources pin level, stores to latch.
// - Direction 1 enables driver; read returns latch.
// - Output pin: read-modify-write sources latch, changing the pin.
// - Per-byte threshold select; two bits for ports 2, 3, 5.
// - Direction and output mode work whatever threshold is chosen.
// - Each line carries one alternate input or output function.
// - Alternate output reaches pin only with direction 1.
// - Driven level is latch AND alternate data.
// - Direction resets to input; software keeps input under external drive.
// - Alternate input sees the output latch when pin is output.
// - Port 0 bus mode switches direction automatically.
// - Port 4 outputs segment address bits 16 to 23 when enabled.
//
// The AXI4-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module pio_group
   import pio_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // AXI4-Lite write address and data
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic [PIO_NPORT-1:0][PIO_W-1:0] pin_in,
   output pio_pad_t [PIO_NPORT-1:0] pad,
   // Input threshold selects toward the pad cells
   output logic [2*PIO_NPORT-1:0] thr_sel,
   // Alternate peripheral functions
   input wire logic [PIO_NPORT-1:0][PIO_W-1:0] alt_data,
   output logic [PIO_NPORT-1:0][PIO_W-1:0] alt_in,
   // External bus controller and segment address
   input wire pio_ebus_t ebus,
   input wire logic [7:0] segment_address_bits,
   output logic [PIO_W-1:0] ebus_rdata
);

   // ************************************************************
   // Register state
   // ************************************************************
   logic [PIO_NPORT-1:0][PIO_W-1:0] latch;
   logic [PIO_NPORT-1:0][PIO_W-1:0] pin_direction_bit;
   logic [PIO_NPORT-1:0][PIO_W-1:0] open_drain_select;
   logic [PIO_NPORT-1:0][PIO_W-1:0] alt_en;
   logic [PIO_NPORT-1:0][PIO_W-1:0] in_latch;
   logic [2*PIO_NPORT-1:0] thr_all;
   logic bus_en;
   logic seg_en;

   // Write decode.
   logic wr_go;
   logic [2:0] wr_bank;
   logic [3:0] wr_idx;
   logic wr_hit;
   logic [PIO_W-1:0] wd;
   logic [PIO_W-1:0] wmask;
   logic [PIO_W-1:0] rmw_src;

   // Read decode.
   logic rd_go;
   logic [2:0] rd_bank;
   logic [3:0] rd_idx;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;

   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   assign wr_bank = s_axi_awaddr[8:6];
   assign wr_idx = s_axi_awaddr[5:2];
   assign wr_hit = (int'(wr_idx) < PIO_NPORT) && (wr_bank < PIO_BANK_MISC) && !s_axi_awaddr[11];
   assign wd = s_axi_wdata[PIO_W-1:0];
   assign wmask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign rd_go = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   assign rd_bank = s_axi_araddr[8:6];
   assign rd_idx = s_axi_araddr[5:2];

   // source of read-modify-write
   // The source picks pin or latch per bit, depending on direction.
   always_comb begin
      rmw_src = '0;
      if (int'(wr_idx) < PIO_NPORT) begin
         rmw_src = (pin_direction_bit[wr_idx] & latch[wr_idx])
                 | (~pin_direction_bit[wr_idx] & in_latch[wr_idx]);
      end
   end

   // ************************************************************
   // Output latches
   // ************************************************************
   // write lands in the latch
   // Set and clear banks are the read-modify-write forms of the data bank.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         latch <= '0;
      end else if (wr_go && wr_hit) begin
         if (wr_bank == PIO_BANK_DATA) begin
            latch[wr_idx] <= ((latch[wr_idx] & ~wmask) | (wd & wmask)) & PIO_IMPL[wr_idx];
         end else if (wr_bank == PIO_BANK_SET) begin
            latch[wr_idx] <= ((latch[wr_idx] & ~wmask) | ((rmw_src | wd) & wmask))
                           & PIO_IMPL[wr_idx];
         end else if (wr_bank == PIO_BANK_CLR) begin
            latch[wr_idx] <= ((latch[wr_idx] & ~wmask) | ((rmw_src & ~wd) & wmask))
                           & PIO_IMPL[wr_idx];
         end
      end
   end

   // direction resets to input
   // Port 5 keeps zeros so it can never be turned into an output.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_direction_bit <= '0;
      end else if (wr_go && wr_hit && wr_bank == PIO_BANK_DIR) begin
         pin_direction_bit[wr_idx] <= ((pin_direction_bit[wr_idx] & ~wmask) | (wd & wmask))
                                    & PIO_IMPL[wr_idx] & {PIO_W{PIO_OUTCAP[wr_idx]}};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         open_drain_select <= '0;
      end else if (wr_go && wr_hit && wr_bank == PIO_BANK_OD) begin
         open_drain_select[wr_idx] <= ((open_drain_select[wr_idx] & ~wmask) | (wd & wmask))
                                    & PIO_IMPL[wr_idx] & {PIO_W{PIO_ODCAP[wr_idx]}};
      end
   end

   // one alternate function per line
   // The enable only chooses whether alternate data gates the latch.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         alt_en <= '0;
      end else if (wr_go && wr_hit && wr_bank == PIO_BANK_ALT) begin
         alt_en[wr_idx] <= ((alt_en[wr_idx] & ~wmask) | (wd & wmask)) & PIO_IMPL[wr_idx];
      end
   end

   // ************************************************************
   // Threshold and mode control
   // ************************************************************
   // byte threshold selects
   // threshold has no effect on direction or mode
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         thr_all <= '0;
         bus_en <= 1'b0;
         seg_en <= 1'b0;
      end else if (wr_go && wr_bank == PIO_BANK_MISC && !s_axi_awaddr[11]) begin
         if (wr_idx == PIO_IDX_THR && s_axi_wstrb[0]) begin
            thr_all[PIO_THR_LO-1:0] <= s_axi_wdata[PIO_THR_LO-1:0]
                                     & PIO_THR_MASK[PIO_THR_LO-1:0];
         end else if (wr_idx == PIO_IDX_XTHR && s_axi_wstrb[0]) begin
            thr_all[2*PIO_NPORT-1:PIO_THR_LO] <= s_axi_wdata[2*PIO_NPORT-PIO_THR_LO-1:0]
                                               & PIO_THR_MASK[2*PIO_NPORT-1:PIO_THR_LO];
         end else if (wr_idx == PIO_IDX_CTL && s_axi_wstrb[0]) begin
            bus_en <= s_axi_wdata[PIO_CTL_BUS];
            seg_en <= s_axi_wdata[PIO_CTL_SEG];
         end
      end
   end

   // Threshold selects leave through their own flops.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         thr_sel <= '0;
      end else begin
         thr_sel <= thr_all;
      end
   end

   // ************************************************************
   // Port slots
   // ************************************************************
   // one slot per port group
   for (genvar i = 0; i < PIO_NPORT; i++) begin : g_port
      logic force_en;
      logic force_dir;
      logic [PIO_W-1:0] force_data;
      // port 0 follows the bus controller
      // port 4 carries the segment address
      always_comb begin
         force_en = 1'b0;
         force_dir = 1'b0;
         force_data = '0;
         if ((i == PIO_P0L || i == PIO_P0H) && bus_en) begin
            force_en = 1'b1;
            force_dir = ebus.drive;
            force_data = (i == PIO_P0L) ? {8'h00, ebus.data[7:0]} : {8'h00, ebus.data[15:8]};
         end else if (i == PIO_P4 && seg_en) begin
            force_en = 1'b1;
            force_dir = 1'b1;
            force_data = {8'h00, segment_address_bits};
         end
      end

      pio_port #(
         .IMPL(PIO_IMPL[i]),
         .OUTCAP(PIO_OUTCAP[i]),
         .ODCAP(PIO_ODCAP[i])
      ) u_port (
         .clk_sys(clk_sys),
         .rst_b(rst_b),
         .pin_in(pin_in[i]),
         .pad(pad[i]),
         .latch(latch[i]),
         .dir(pin_direction_bit[i]),
         .od(open_drain_select[i]),
         .alt_en(alt_en[i]),
         .alt_data(alt_data[i]),
         .force_en(force_en),
         .force_dir(force_dir),
         .force_data(force_data),
         .in_latch(in_latch[i]),
         .alt_in(alt_in[i])
      );
   end

   // Data read back toward the bus controller in its input phase.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ebus_rdata <= '0;
      end else begin
         ebus_rdata <= {in_latch[PIO_P0H][7:0], in_latch[PIO_P0L][7:0]};
      end
   end

   // ************************************************************
   // AXI4-Lite write channel
   // ************************************************************
   // Address and data are taken together; the response waits for both.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= PIO_RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready <= wr_go;
         if (wr_go) begin
            s_axi_bresp <= (wr_hit || (wr_bank == PIO_BANK_MISC && !s_axi_awaddr[11]
                            && wr_idx <= PIO_IDX_CTL)) ? PIO_RESP_OKAY : PIO_RESP_SLVERR;
         end
         if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // AXI4-Lite read channel
   // ************************************************************
   // read picks pin or latch
   // Unmapped words below 0x200 or from 0x800 answer zero with SLVERR; 0x200 to 0x7FF repeat the map, as bits 10:9 are not decoded.
   always_comb begin
      next_rdata = '0;
      next_rresp = PIO_RESP_OKAY;
      if (s_axi_araddr[11]) begin
         next_rresp = PIO_RESP_SLVERR;
      end else if (rd_bank == PIO_BANK_MISC) begin
         if (rd_idx == PIO_IDX_THR) begin
            next_rdata[PIO_THR_LO-1:0] = thr_all[PIO_THR_LO-1:0];
         end else if (rd_idx == PIO_IDX_XTHR) begin
            next_rdata[2*PIO_NPORT-PIO_THR_LO-1:0] = thr_all[2*PIO_NPORT-1:PIO_THR_LO];
         end else if (rd_idx == PIO_IDX_CTL) begin
            next_rdata[PIO_CTL_BUS] = bus_en;
            next_rdata[PIO_CTL_SEG] = seg_en;
         end else begin
            next_rresp = PIO_RESP_SLVERR;
         end
      end else if (int'(rd_idx) >= PIO_NPORT || rd_bank > PIO_BANK_MISC) begin
         next_rresp = PIO_RESP_SLVERR;
      end else begin
         case (rd_bank)
            PIO_BANK_DIR: next_rdata[PIO_W-1:0] = pin_direction_bit[rd_idx];
            PIO_BANK_OD: next_rdata[PIO_W-1:0] = open_drain_select[rd_idx];
            PIO_BANK_ALT: next_rdata[PIO_W-1:0] = alt_en[rd_idx];
            default: next_rdata[PIO_W-1:0] = (pin_direction_bit[rd_idx] & latch[rd_idx])
                                           | (~pin_direction_bit[rd_idx] & in_latch[rd_idx]);
         endcase
      end
   end

   // Read data is captured with the address and shown one cycle later.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= PIO_RESP_OKAY;
      end else begin
         s_axi_arready <= rd_go;
         if (rd_go) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
         end
         if (s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   // input pin reads the sampled level
   chk_read_input: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (rd_go && rd_bank == PIO_BANK_DATA && rd_idx == 4'h4 && !s_axi_araddr[11])
      |=> ((s_axi_rdata[PIO_W-1:0] & ~$past(pin_direction_bit[4]))
           == ($past(in_latch[4]) & ~$past(pin_direction_bit[4]))))
      else $error("read of input pin did not return sampled level");
   chk_read_output: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (rd_go && rd_bank == PIO_BANK_DATA && rd_idx == 4'h4 && !s_axi_araddr[11])
      |=> ##1 (s_axi_rvalid && ((s_axi_rdata[PIO_W-1:0] & $past(pin_direction_bit[4], 2))
                                == ($past(latch[4], 2) & $past(pin_direction_bit[4], 2)))))
      else $error("read of output pin did not return latch");
   chk_rmw_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (wr_go && wr_hit && wr_bank == PIO_BANK_SET && wr_idx == 4'h4 && s_axi_wstrb[1:0] == 2'h3)
      |=> (latch[4] == (($past(pin_direction_bit[4]) & $past(latch[4]))
                       | (~$past(pin_direction_bit[4]) & $past(in_latch[4])) | $past(wd))))
      else $error("set access did not merge source and data");
   // bus drive phase enables port 0
   chk_bus_dir: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (bus_en && ebus.drive) |=> (pad[PIO_P0L].oe == PIO_IMPL[PIO_P0L]))
      else $error("port 0 not driven in bus address phase");
   chk_seg_out: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (seg_en && !open_drain_select[PIO_P4][0])
      |=> (pad[PIO_P4].out[0] == $past(segment_address_bits[0])))
      else $error("segment address bit not on port 4");
   // pushed level is latch AND alternate
   chk_and_level: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!bus_en && pin_direction_bit[4][0] && !open_drain_select[4][0] && alt_en[4][0])
      |=> (pad[4].out[0] == ($past(latch[4][0]) & $past(alt_data[4][0]))))
      else $error("driven level is not latch AND alternate data");
   chk_dir_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (wr_go && wr_hit && wr_bank == PIO_BANK_DIR && wr_idx == 4'h7)
      |=> (pin_direction_bit[PIO_P5] == '0))
      else $error("input only port accepted a direction bit");

endmodule // pio_group

/* rtl/pio_pkg.sv */
// Constants, layouts and carrier types of the parallel I/O port group.
// Assumes one 40 MHz system clock and an AXI4-Lite register master.
package pio_pkg;

   // ************************************************************
   // Port slots and pin capabilities
   // ************************************************************
   localparam int PIO_NPORT = 11;
   localparam int PIO_W = 16;
   // Slots: 0 port0_low_byte, 1 port0_high_byte, 2 port1_low_byte,
   // 3 port1_high_byte, 4 port 2, 5 port 3, 6 port 4, 7 port 5,
   // 8 port 6, 9 port 7, 10 port 8.
   localparam int PIO_P0L = 0;
   localparam int PIO_P0H = 1;
   localparam int PIO_P4 = 6;
   localparam int PIO_P5 = 7;
   // Lines that exist; port3_line14 is absent.
   localparam logic [PIO_NPORT-1:0][PIO_W-1:0] PIO_IMPL = {
      16'h00FF, 16'h00FF, 16'h00FF, 16'hFFFF, 16'h00FF, 16'hBFFF,
      16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF};
   // Slots with an output driver (port 5 is input only).
   localparam logic [PIO_NPORT-1:0] PIO_OUTCAP = 11'h77F;
   // Slots with open_drain_select (ports 2, 3, 4, 6, 7, 8).
   localparam logic [PIO_NPORT-1:0] PIO_ODCAP = 11'h770;
   // Threshold bits per slot: one per byte, two for ports 2, 3, 5.
   localparam logic [2*PIO_NPORT-1:0] PIO_THR_MASK = 22'h15DF55;
   localparam int PIO_THR_LO = 14;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [2:0] PIO_BANK_DATA = 3'h0;  // 0x000 + 4*slot
   localparam logic [2:0] PIO_BANK_DIR = 3'h1;   // 0x040 + 4*slot
   localparam logic [2:0] PIO_BANK_OD = 3'h2;    // 0x080 + 4*slot
   localparam logic [2:0] PIO_BANK_ALT = 3'h3;   // 0x0C0 + 4*slot
   localparam logic [2:0] PIO_BANK_SET = 3'h4;   // 0x100 + 4*slot
   localparam logic [2:0] PIO_BANK_CLR = 3'h5;   // 0x140 + 4*slot
   localparam logic [2:0] PIO_BANK_MISC = 3'h6;  // 0x180 ...
   localparam logic [3:0] PIO_IDX_THR = 4'h0;    // 0x180
   localparam logic [3:0] PIO_IDX_XTHR = 4'h1;   // 0x184
   localparam logic [3:0] PIO_IDX_CTL = 4'h2;    // 0x188
   localparam int PIO_CTL_BUS = 0;
   localparam int PIO_CTL_SEG = 1;
   localparam logic [1:0] PIO_RESP_OKAY = 2'h0;
   localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

   // ************************************************************
   // Carrier types
   // ************************************************************
   typedef struct packed {
      logic [PIO_W-1:0] out;
      logic [PIO_W-1:0] oe;
   } pio_pad_t;

   typedef struct packed {
      logic drive;
      logic [PIO_W-1:0] data;
   } pio_ebus_t;
endpackage

/* rtl/pio_port.sv */
// One port slot: input latch, output latch combining and pad drive.
// Assumes pins arrive unsynchronised and control comes from clk_sys.
`timescale 1ns/1ps
module pio_port
   import pio_pkg::*;
#(
   parameter logic [PIO_W-1:0] IMPL = 16'hFFFF,
   parameter logic OUTCAP = 1'b1,
   parameter logic ODCAP = 1'b0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Pins
   input wire logic [PIO_W-1:0] pin_in,
   output pio_pad_t pad,
   // Control from the register file
   input wire logic [PIO_W-1:0] latch,
   input wire logic [PIO_W-1:0] dir,
   input wire logic [PIO_W-1:0] od,
   input wire logic [PIO_W-1:0] alt_en,
   input wire logic [PIO_W-1:0] alt_data,
   input wire logic force_en,
   input wire logic force_dir,
   input wire logic [PIO_W-1:0] force_data,
   // Results
   output logic [PIO_W-1:0] in_latch,
   output logic [PIO_W-1:0] alt_in
);
   logic [PIO_W-1:0] sync1;
   logic [PIO_W-1:0] eff_dir;
   logic [PIO_W-1:0] value;
   logic [PIO_W-1:0] odm;

   // sample every cycle
   // The first stage feeds only the input latch; nothing else reads it.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1 <= '0;
         in_latch <= '0;
      end else begin
         sync1 <= pin_in;
         in_latch <= sync1 & IMPL;
      end
   end

   // hardware direction override
   // A bus or segment function steers direction and data by itself.
   assign eff_dir = (force_en ? {PIO_W{force_dir}} : dir) & IMPL & {PIO_W{OUTCAP}};
   assign value = force_en ? force_data : (latch & (alt_data | ~alt_en));
   assign odm = od & {PIO_W{ODCAP}};

   // open drain pulls low or releases
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pad <= '0;
      end else begin
         pad.out <= value & ~odm & eff_dir;
         pad.oe <= eff_dir & ~(odm & value);
      end
   end

   // alternate input follows the latch on outputs
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         alt_in <= '0;
      end else begin
         alt_in <= ((dir & latch) | (~dir & in_latch)) & IMPL;
      end
   end

   chk_input_latch: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $past(rst_b, 2) |-> (in_latch == ($past(pin_in, 2) & IMPL)))
      else $error("input latch does not follow pin two cycles later");
   chk_od_low_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ##1 ((pad.out & $past(odm)) == '0))
      else $error("open drain pin driven high");
   chk_no_drive: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (!force_en && (dir == '0)) |=> (pad.oe == '0))
      else $error("pad enabled while direction is input");
   chk_input_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !OUTCAP |-> (pad.oe == '0))
      else $error("input only port drives a pin");
endmodule // pio_port
